// ===== dv/tb_wdc_top.sv
// Self-checking bench for the watchdog control block.
// Assumes wdc_pkg, wdc_top and the processor model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_wdc_top;
    import wdc_pkg::*;
    localparam int TD = 4;
    logic clk;
    logic nrst;
    logic wprot;
    logic [2:0] nvm_b;
    logic [11:0] nvm_c;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic wr;
    logic rd;
    logic irq;
    logic sys_rst;
    logic running;
    logic irq_q;
    int mismatches;
    int comparisons;
    int cyc;
    int rst_at;
    int rst_gap;
    int rst_cnt;
    int irq_at;
    int k;

    wdc_top #(.TICK_DIV(TD)) wdc_top_inst (
        .REF_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .BE_I(be),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .WPROT_I(wprot), .NVM_LOCK_I(nvm_b[2]),
        .NVM_WEN_I(nvm_b[1]), .NVM_EN_I(nvm_b[0]), .NVM_CLOSED_I(nvm_c[11:8]),
        .NVM_PER_I(nvm_c[7:4]), .NVM_EW_I(nvm_c[3:0]), .IRQ_O(irq),
        .SYS_RESET_O(sys_rst), .RUNNING_O(running)
    );
    wdc_cpu cpu (
        .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .be_o(be), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata)
    );

    // 250 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Stamp reset pulses and interrupt rises in reference cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        irq_q <= irq;
        if (sys_rst === 1'b1) begin
            rst_at <= cyc;
            rst_gap <= cyc - rst_at;
            rst_cnt <= rst_cnt + 1;
        end
        if (irq === 1'b1 && irq_q !== 1'b1) begin
            irq_at <= cyc;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdc(input string what, input logic [1:0] a, input logic [31:0] exp);
        logic [31:0] d;
        cpu.rd(a, d);
        check(what, exp, d);
    endtask

    // Bounded wait on the running flag, or on a number of reset pulses
    task automatic wait_run(input logic lvl);
        int n;
        n = 0;
        while (running !== lvl && n < 64) begin
            @(posedge clk);
            n++;
        end
        if (running !== lvl) begin
            check("running wait", lvl, running);
            wrap_up();
        end
    endtask

    task automatic wait_rst(input int p);
        int t;
        int n;
        t = rst_cnt + p;
        n = 0;
        while (rst_cnt < t && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (rst_cnt < t) begin
            check("reset pulse wait", t, rst_cnt);
            wrap_up();
        end
    endtask

    // Stop, program periods, then start with the given control byte
    task automatic set_wd(input logic [7:0] ctl, input logic [7:0] cfg, input logic [3:0] ew);
        cpu.wr(2'h0, 4'h1, 32'h0);
        wait_run(1'b0);
        cpu.wr(2'h0, 4'h6, {12'h0, ew, cfg, 8'h0});
        cpu.wr(2'h0, 4'h1, {24'h0, ctl});
        wait_run(1'b1);
    endtask

    // Clear the flag, then measure the warning delay from period start
    task automatic ew_chk(input int exp);
        cpu.wr(2'h1, 4'h4, 32'h0001_0000);
        repeat (exp) @(posedge clk);
        check("warning delay", 1'b1, (irq_at - rst_at) inside {[exp - 1:exp + 1]});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {mismatches, comparisons, cyc, rst_at, rst_gap, rst_cnt, irq_at} = '0;
        irq_q = 1'b0;
        wprot = 1'b0;
        nvm_b = 3'b010;
        nvm_c = 12'h312;
        nrst = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("startup word0", 2'h0, 32'h0002_3104);
        rdc("startup word1", 2'h1, 32'h0);
        rdc("unmapped word", 2'h3, 32'h0);
        check("startup running", 1'b0, running);
        $display("test startup done");
        cpu.wr(2'h0, 4'h2, 32'h0000_5200);
        rdc("byte lane", 2'h0, 32'h0002_5204);
        cpu.wr(2'h0, 4'h2, 32'h0000_dc00);
        rdc("reserved codes kept", 2'h0, 32'h0002_dc04);
        cpu.wr(2'h0, 4'h6, 32'h0003_2100);
        rdc("half word", 2'h0, 32'h0003_2104);
        @(posedge clk);
        wprot <= 1'b1;
        cpu.wr(2'h0, 4'h6, 32'h0005_1100);
        cpu.wr(2'h1, 4'h2, 32'h0000_0100);
        wprot <= 1'b0;
        rdc("guarded word0", 2'h0, 32'h0003_1104);
        rdc("guarded word1", 2'h1, 32'h0);
        $display("test lanes done");
        cpu.wr(2'h0, 4'h1, 32'h0000_0002);
        rdc("busy set", 2'h1, 32'h8000_0000);
        rdc("enable readback", 2'h0, 32'h0003_1102);
        wait_run(1'b1);
        rdc("busy clear", 2'h1, 32'h0);
        cpu.wr(2'h0, 4'h1, 32'h0000_0006);
        rdc("window protected", 2'h0, 32'h0003_1102);
        $display("test enable done");
        set_wd(8'h02, 8'h0b, 4'h0);
        k = rst_cnt;
        cpu.wr(2'h2, 4'h1, 32'h0000_00a5);
        repeat (60) @(posedge clk);
        check("good key", k, rst_cnt);
        rdc("flag without enable", 2'h1, 32'h0001_0000);
        check("irq masked", 1'b0, irq);
        cpu.wr(2'h1, 4'h2, 32'h0000_0100);
        #1;
        check("irq enabled", 1'b1, irq);
        cpu.wr(2'h1, 4'h1, 32'h0000_0001);
        #1;
        check("irq disabled", 1'b0, irq);
        cpu.wr(2'h1, 4'h2, 32'h0000_0100);
        cpu.wr(2'h1, 4'h4, 32'h0001_0000);
        #1;
        check("irq flag cleared", 1'b0, irq);
        k = rst_cnt;
        cpu.wr(2'h2, 4'h1, 32'h0000_005a);
        repeat (3) @(posedge clk);
        check("bad key", k + 1, rst_cnt);
        $display("test key done");
        for (int c = 0; c < 3; c++) begin
            set_wd(8'h02, 8'(c + 1), 4'(c));
            wait_rst(2);
            check("timeout gap", 32'((8 << (c + 1)) * TD), 32'(rst_gap));
            ew_chk((8 << c) * TD);
        end
        $display("test timeout done");
        set_wd(8'h06, 8'h10, 4'h0);
        wait_rst(2);
        check("window gap", 32'(24 * TD), 32'(rst_gap));
        ew_chk(16 * TD);
        k = rst_cnt;
        cpu.wr(2'h2, 4'h1, 32'h0000_00a5);
        repeat (20) @(posedge clk);
        check("open window key", k, rst_cnt);
        cpu.wr(2'h2, 4'h1, 32'h0000_00a5);
        repeat (16) @(posedge clk);
        check("closed window key", k + 1, rst_cnt);
        $display("test window done");
        set_wd(8'h02, 8'h10, 4'h0);
        cpu.wr(2'h0, 4'h1, 32'h0000_0082);
        cpu.wr(2'h0, 4'h1, 32'h0000_0004);
        rdc("lock held", 2'h0, 32'h0000_1086);
        cpu.wr(2'h0, 4'h6, 32'h0005_3300);
        repeat (40) @(posedge clk);
        rdc("locked config", 2'h0, 32'h0000_1086);
        check("locked running", 1'b1, running);
        $display("test lock done");
        @(posedge clk);
        nvm_b <= 3'b100;
        nvm_c <= 12'h021;
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        check("reset running", 1'b0, running);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("second startup", 2'h0, 32'h0001_0280);
        check("nvm lock running", 1'b1, running);
        $display("test power on done");
        wrap_up();
    end
endmodule // tb_wdc_top
`default_nettype wire

// ===== dv/wdc_cpu.sv
// Processor model: a plain register-port bus master.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module wdc_cpu (
    input wire logic clk_i,
    output logic [1:0] addr_o,
    output logic [31:0] wdata_o,
    output logic [3:0] be_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i
);
    // Writable bits of each word; reserved bits go out as zero in every write cycle
    localparam logic [127:0] WMASK = 128'h00000000_000000ff_00010101_000fff86;

    // Idle bus at time zero
    initial begin
        addr_o = 2'h0;
        wdata_o = 32'h0;
        be_o = 4'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One-cycle write; data scrambled afterwards so stale lanes never look valid
    task automatic wr(input logic [1:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        be_o <= b;
        wdata_o <= d & WMASK[{a, 5'h00} +: 32];
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask

    // One-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule // wdc_cpu
`default_nettype wire

// ===== src/wdc_pkg.sv
// Constants, field layout and phase codes of the watchdog control block.
// Assumes a single 250 MHz reference clock; the count clock is an enable pulse.
package wdc_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets (word address = offset[3:2], lane = [1:0])
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CONFIG = 4'h1;
    localparam logic [3:0] OFS_EARLY_WARNING_CONTROL = 4'h2;
    localparam logic [3:0] OFS_IEN_CLR = 4'h4;
    localparam logic [3:0] OFS_IEN_SET = 4'h5;
    localparam logic [3:0] OFS_FLAGS = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_KEY = 4'h8;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_LOCK_BIT = 7;
    localparam int CTRL_WEN_BIT = 2;
    localparam int CTRL_EN_BIT = 1;
    localparam int CFG_CLOSED_LSB = 4;
    localparam int CFG_PER_LSB = 0;
    localparam int EW_DELAY_LSB = 0;
    localparam int IRQ_EW_BIT = 0;
    localparam int STATUS_BUSY_BIT = 7;

    // ---------------------------------------------------------------
    // Values and timing counts
    // ---------------------------------------------------------------
    localparam logic [7:0] RESTART_KEY = 8'ha5;
    localparam logic [3:0] CODE_MAX = 4'hb;
    localparam logic [15:0] BASE_CYCLES = 16'h0008;
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    localparam int BUS_WIDTH = 32;

    // Watchdog period phases
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_NORMAL = 2'b01,
        PH_CLOSED = 2'b10,
        PH_OPEN = 2'b11
    } wdc_phase_e;

    // Period length for a code; reserved codes saturate to the longest one
    function automatic logic [15:0] wdc_cycles(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        return BASE_CYCLES << c;
    endfunction

endpackage

// ===== src/wdc_top.sv
// Watchdog control registers, count logic and early-warning interrupt.
// Assumes a plain register port driven on the reference clock and NVM
// settings held stable at the inputs around reset release.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] Byte, half-word and word accesses via byte enables, each atomic.
// [R2] Enable-protected fields change only while the watchdog is disabled or locked.
// [R3] Access-protection write guard blocks write-protected registers.
// [R4] Run lock once set cannot be cleared; only power-on reset stops it.
// [R5] Lock clear: enable bit decides running; lock set: always running.
// [R6] Lock set makes period and warning registers read-only; in control only window enable stays writable.
// [R7] Lock, window, enable and period codes load from NVM at startup.
// [R8] Reserved bits read zero; software writes zeros there.
// [R9] Window enable writable when enable is zero or lock is one.
// [R10] Window bit zero gives single period; one gives closed then open.
// [R11] Enable bit writable only while lock is zero.
// [R12] Enable write reads back at once, sets busy, busy clears after sync.
// [R13] Closed window is 8 times two to the code cycles, codes 0 to 0xB.
// [R14] Time-out code 0 is 8 cycles, each code doubles, up to 0xB.
// [R15] In window mode the time-out code sets the open window length.
// [R16] Early warning fires that many count cycles after period start; in window mode at open window start.
// [R17] Key 0xA5 restarts the period; any other value resets the system.
// [R18] A restart inside the closed window resets the system.
// [R19] Interrupt is flag and enable, held until either clears or reset.
// [R20] Reserved period codes saturate to the longest defined setting.
module wdc_top
    import wdc_pkg::*;
#(
    parameter int TICK_DIV = 250
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] BE_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic WPROT_I,
    input wire logic NVM_LOCK_I,
    input wire logic NVM_WEN_I,
    input wire logic NVM_EN_I,
    input wire logic [3:0] NVM_CLOSED_I,
    input wire logic [3:0] NVM_PER_I,
    input wire logic [3:0] NVM_EW_I,
    output logic IRQ_O,
    output logic SYS_RESET_O,
    output logic RUNNING_O
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
        $error("TICK_DIV must lie in 1 to 65535");
    end

    localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic loaded;
        logic lock;
        logic wen;
        logic enable;
        logic run_en;
        logic [3:0] closed_code;
        logic [3:0] per_code;
        logic [3:0] ew_code;
        logic irq_en;
        logic ew_flag;
        logic busy;
        logic [1:0] sync_cnt;
        logic en_pend;
        logic key_pend;
        wdc_phase_e phase;
        logic [15:0] count;
        logic [15:0] div_cnt;
        logic rst_pulse;
        logic [31:0] rdata;
    } wdc_state_s;

    wdc_state_s s_r;
    wdc_state_s s_nxt;

    // ---------------------------------------------------------------
    // Write decode per register byte
    // ---------------------------------------------------------------
    logic we_ctrl, we_cfg, we_ew, we_iclr, we_iset, we_flag, we_key;
    logic [7:0] d_ctrl, d_cfg, d_ew, d_iclr, d_iset, d_flag, d_key;
    logic tick, running, key_go;
    logic [15:0] cyc_closed, cyc_per, cyc_ew;

    // Byte lane enables select each register on its own lane of a shared word
    assign we_ctrl = WR_I && ADDR_I == OFS_CTRL[3:2] && BE_I[OFS_CTRL[1:0]]; // see [R1]
    assign we_cfg = WR_I && ADDR_I == OFS_CONFIG[3:2] && BE_I[OFS_CONFIG[1:0]];
    assign we_ew = WR_I && ADDR_I == OFS_EARLY_WARNING_CONTROL[3:2] && BE_I[OFS_EARLY_WARNING_CONTROL[1:0]];
    assign we_iclr = WR_I && ADDR_I == OFS_IEN_CLR[3:2] && BE_I[OFS_IEN_CLR[1:0]];
    assign we_iset = WR_I && ADDR_I == OFS_IEN_SET[3:2] && BE_I[OFS_IEN_SET[1:0]];
    assign we_flag = WR_I && ADDR_I == OFS_FLAGS[3:2] && BE_I[OFS_FLAGS[1:0]];
    assign we_key = WR_I && ADDR_I == OFS_KEY[3:2] && BE_I[OFS_KEY[1:0]];
    assign d_ctrl = WDATA_I[8*OFS_CTRL[1:0] +: 8];
    assign d_cfg = WDATA_I[8*OFS_CONFIG[1:0] +: 8];
    assign d_ew = WDATA_I[8*OFS_EARLY_WARNING_CONTROL[1:0] +: 8];
    assign d_iclr = WDATA_I[8*OFS_IEN_CLR[1:0] +: 8];
    assign d_iset = WDATA_I[8*OFS_IEN_SET[1:0] +: 8];
    assign d_flag = WDATA_I[8*OFS_FLAGS[1:0] +: 8];
    assign d_key = WDATA_I[8*OFS_KEY[1:0] +: 8];

    // Count clock enable, run state and period lengths
    assign tick = s_r.div_cnt == DIV_LAST;
    assign running = s_r.loaded && (s_r.run_en || s_r.lock); // see [R5]
    assign cyc_closed = wdc_cycles(s_r.closed_code); // see [R13] [R20]
    assign cyc_per = wdc_cycles(s_r.per_code); // see [R14] [R15] [R20]
    assign cyc_ew = wdc_cycles(s_r.ew_code); // see [R16] [R20]
    assign key_go = s_r.busy && tick && s_r.sync_cnt == SYNC_TICKS - 2'h1 && s_r.key_pend;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic [15:0] cn;
        logic ew_set;
        cn = s_r.count + 16'h0001;
        ew_set = 1'b0;
        s_nxt = s_r;
        s_nxt.rst_pulse = 1'b0;
        s_nxt.rdata = '0;
        s_nxt.div_cnt = tick ? 16'h0000 : s_r.div_cnt + 16'h0001;

        if (!s_r.loaded) begin
            // First cycle after reset: take the stored user settings
            s_nxt.loaded = 1'b1; // see [R7]
            s_nxt.lock = NVM_LOCK_I;
            s_nxt.wen = NVM_WEN_I;
            s_nxt.enable = NVM_EN_I;
            s_nxt.run_en = NVM_EN_I;
            s_nxt.closed_code = NVM_CLOSED_I;
            s_nxt.per_code = NVM_PER_I;
            s_nxt.ew_code = NVM_EW_I;
        end else begin
            // Period counter and phase sequencing
            if (!running) begin
                s_nxt.phase = PH_IDLE;
                s_nxt.count = '0;
            end else if (s_r.phase == PH_IDLE) begin
                s_nxt.phase = s_r.wen ? PH_CLOSED : PH_NORMAL; // see [R10]
                s_nxt.count = '0;
            end else if (tick) begin
                s_nxt.count = cn;
                unique case (s_r.phase)
                    PH_NORMAL: begin
                        if (cn == cyc_ew) begin
                            ew_set = 1'b1; // see [R16]
                        end
                        if (cn == cyc_per) begin
                            s_nxt.rst_pulse = 1'b1; // see [R14]
                            s_nxt.phase = s_r.wen ? PH_CLOSED : PH_NORMAL;
                            s_nxt.count = '0;
                        end
                    end
                    PH_CLOSED: begin
                        if (cn == cyc_closed) begin
                            s_nxt.phase = PH_OPEN; // see [R13]
                            s_nxt.count = '0;
                            ew_set = 1'b1;
                        end
                    end
                    PH_OPEN: begin
                        if (cn == cyc_per) begin
                            s_nxt.rst_pulse = 1'b1; // see [R15]
                            s_nxt.phase = s_r.wen ? PH_CLOSED : PH_NORMAL;
                            s_nxt.count = '0;
                        end
                    end
                    PH_IDLE: begin
                        s_nxt.count = '0;
                    end
                endcase
            end

            // Synchronisation to the count clock completes after a few ticks
            if (s_r.busy && tick) begin
                s_nxt.sync_cnt = s_r.sync_cnt + 2'h1;
                if (s_r.sync_cnt == SYNC_TICKS - 2'h1) begin
                    s_nxt.busy = 1'b0; // see [R12]
                    s_nxt.en_pend = 1'b0;
                    s_nxt.key_pend = 1'b0;
                    if (s_r.en_pend) begin
                        s_nxt.run_en = s_r.enable;
                    end
                    if (key_go && running) begin
                        if (s_r.phase == PH_CLOSED) begin
                            s_nxt.rst_pulse = 1'b1; // see [R18]
                        end
                        s_nxt.phase = s_r.wen ? PH_CLOSED : PH_NORMAL; // see [R17]
                        s_nxt.count = '0;
                    end
                end
            end

            // Control register writes
            if (we_ctrl) begin
                if (s_r.lock || !s_r.enable) begin
                    s_nxt.wen = d_ctrl[CTRL_WEN_BIT]; // see [R9] [R2]
                end
                if (!s_r.lock) begin
                    s_nxt.lock = d_ctrl[CTRL_LOCK_BIT]; // see [R4] [R6]
                    s_nxt.enable = d_ctrl[CTRL_EN_BIT]; // see [R11]
                    s_nxt.en_pend = 1'b1;
                    s_nxt.busy = 1'b1; // see [R12]
                    s_nxt.sync_cnt = '0;
                end
            end
            // Period configuration, frozen under the lock
            if (we_cfg && !s_r.lock) begin
                s_nxt.closed_code = d_cfg[CFG_CLOSED_LSB +: 4]; // see [R6]
                s_nxt.per_code = d_cfg[CFG_PER_LSB +: 4];
            end
            // Early-warning delay, frozen under the lock and write guard
            if (we_ew && !s_r.lock && !WPROT_I) begin
                s_nxt.ew_code = d_ew[EW_DELAY_LSB +: 4]; // see [R3] [R6]
            end
            // Interrupt enable set and clear
            if (we_iclr && !WPROT_I && d_iclr[IRQ_EW_BIT]) begin
                s_nxt.irq_en = 1'b0; // see [R3]
            end
            if (we_iset && !WPROT_I && d_iset[IRQ_EW_BIT]) begin
                s_nxt.irq_en = 1'b1;
            end
            // Restart key: good key synchronises, bad key resets at once
            if (we_key && !WPROT_I) begin
                if (d_key == RESTART_KEY) begin
                    s_nxt.key_pend = 1'b1; // see [R17]
                    s_nxt.busy = 1'b1;
                    s_nxt.sync_cnt = '0;
                end else begin
                    s_nxt.rst_pulse = 1'b1; // see [R17]
                end
            end
            // Flag clear by writing one; a new event wins over the clear
            if (we_flag && d_flag[IRQ_EW_BIT]) begin
                s_nxt.ew_flag = 1'b0;
            end
            if (ew_set) begin
                s_nxt.ew_flag = 1'b1; // see [R19]
            end
        end

        // Read data, reserved bits and unmapped bytes as zero
        if (RD_I) begin
            unique case (ADDR_I)
                OFS_CTRL[3:2]: begin
                    s_nxt.rdata[8*OFS_CTRL[1:0] + CTRL_LOCK_BIT] = s_r.lock; // see [R8]
                    s_nxt.rdata[8*OFS_CTRL[1:0] + CTRL_WEN_BIT] = s_r.wen;
                    s_nxt.rdata[8*OFS_CTRL[1:0] + CTRL_EN_BIT] = s_r.enable;
                    s_nxt.rdata[8*OFS_CONFIG[1:0] +: 8] = {s_r.closed_code, s_r.per_code};
                    s_nxt.rdata[8*OFS_EARLY_WARNING_CONTROL[1:0] + EW_DELAY_LSB +: 4] = s_r.ew_code;
                end
                OFS_IEN_CLR[3:2]: begin
                    s_nxt.rdata[8*OFS_IEN_CLR[1:0] + IRQ_EW_BIT] = s_r.irq_en;
                    s_nxt.rdata[8*OFS_IEN_SET[1:0] + IRQ_EW_BIT] = s_r.irq_en;
                    s_nxt.rdata[8*OFS_FLAGS[1:0] + IRQ_EW_BIT] = s_r.ew_flag;
                    s_nxt.rdata[8*OFS_STATUS[1:0] + STATUS_BUSY_BIT] = s_r.busy;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign RDATA_O = s_r.rdata;
    assign IRQ_O = s_r.ew_flag && s_r.irq_en; // see [R19]
    assign SYS_RESET_O = s_r.rst_pulse;
    assign RUNNING_O = running;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    localparam int BUSY_MAX = 2 * TICK_DIV + 2;
    logic [17:0] busy_age_r;

    // Cycles spent busy since the last bus write
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_age_r <= '0;
        end else if (!s_r.busy || (s_nxt.sync_cnt == 2'h0 && s_r.sync_cnt != 2'h0)
                     || WR_I) begin
            busy_age_r <= '0;
        end else begin
            busy_age_r <= busy_age_r + 18'h00001;
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // Steps of an enable write and of the closed window ending
    sequence ctrl_write_s;
        s_r.loaded && !s_r.lock && we_ctrl;
    endsequence
    sequence closed_ends_s;
        s_r.phase == PH_CLOSED ##1 s_r.phase == PH_OPEN;
    endsequence

    // Run lock, the registers that it freezes and the window enable guard
    lock_sticky_a: assert property (s_r.loaded && s_r.lock |=> s_r.lock) // see [R4]
        else $error("run lock was cleared");
    lock_runs_a: assert property (s_r.loaded && s_r.lock |-> RUNNING_O) // see [R5]
        else $error("locked watchdog not running");
    locked_cfg_a: assert property (s_r.loaded && s_r.lock && (we_cfg || we_ew)
        |=> $stable(s_r.per_code) && $stable(s_r.closed_code) && $stable(s_r.ew_code)) // see [R6]
        else $error("locked configuration changed");
    wen_guard_a: assert property (s_r.loaded && !s_r.lock && s_r.enable && we_ctrl
        |=> $stable(s_r.wen)) // see [R9]
        else $error("window enable written while enabled");
    // Access-protection guard and the enable write answer
    wprot_ew_a: assert property (s_r.loaded && WPROT_I && (we_ew || we_iset)
        |=> $stable(s_r.ew_code) && $stable(s_r.irq_en)) // see [R3]
        else $error("protected register written");
    enable_readback_a: assert property (ctrl_write_s
        |=> s_r.busy && s_r.enable == $past(d_ctrl[CTRL_EN_BIT])) // see [R12]
        else $error("enable write not reflected or busy not set");
    busy_bound_a: assert property (busy_age_r <= 18'(BUSY_MAX)) // see [R12]
        else $error("synchronisation busy held too long");
    // Restart key, window and time-out resets, and the open window warning
    bad_key_a: assert property (s_r.loaded && we_key && !WPROT_I && d_key != RESTART_KEY
        |=> SYS_RESET_O) // see [R17]
        else $error("bad key did not reset");
    closed_key_a: assert property (key_go && running && s_r.phase == PH_CLOSED
        |=> SYS_RESET_O) // see [R18]
        else $error("restart in closed window did not reset");
    open_warn_a: assert property (closed_ends_s |-> s_r.ew_flag) // see [R16]
        else $error("no warning at open window start");
    timeout_a: assert property (running && s_r.phase == PH_NORMAL && tick
        && s_r.count + 16'h0001 == cyc_per && !we_key |=> SYS_RESET_O) // see [R14]
        else $error("time-out did not reset");
    // Reserved codes land on the longest defined setting, never beyond it
    period_sat_a: assert property (cyc_per <= 16'h4000 && cyc_closed <= 16'h4000
        && (s_r.per_code <= CODE_MAX || cyc_per == 16'h4000)
        && (s_r.closed_code <= CODE_MAX || cyc_closed == 16'h4000)
        && (s_r.ew_code <= CODE_MAX || cyc_ew == 16'h4000)) // see [R20]
        else $error("period beyond longest setting");
    reserved_zero_a: assert property (RD_I && ADDR_I == OFS_CTRL[3:2]
        |=> RDATA_O[6:3] == 4'h0 && RDATA_O[0] == 1'b0 && RDATA_O[31:28] == 4'h0) // see [R8]
        else $error("reserved bits read non-zero");

    // Read data stand only in the cycle after the read strobe
    rdata_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0) // see [R1]
        else $error("read data outside the answer cycle");

    // Enable set and clear act on the one shared enable bit; set wins
    irq_set_a: assert property (s_r.loaded && !WPROT_I && we_iset && d_iset[IRQ_EW_BIT]
        |=> s_r.irq_en) // see [R19]
        else $error("interrupt enable set lost");
    irq_clr_a: assert property (s_r.loaded && !WPROT_I && we_iclr && d_iclr[IRQ_EW_BIT]
        && !(we_iset && d_iset[IRQ_EW_BIT]) |=> !s_r.irq_en) // see [R19]
        else $error("interrupt enable clear lost");

endmodule // wdc_top

`default_nettype wire
